// ### logic/istream_xlate_and_exception_regs.sv
/*
 * instruction-unit register bank: translation buffer maintenance, fault
 * address formatting, page table base, icache parity and flush, restart
 * address and arithmetic trap summary.
 * assumes accesses arrive as single-cycle move-to/move-from requests on the
 * core clock; read data is returned one cycle after the request.
 */
`default_nettype none

module istream_xlate_and_exception_regs #(
   parameter int entries = 48
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register access
   input wire ixr_pkg::ipr_req_t req,
   output logic [63:0] rdata,
   output logic rvalid,
   // hardware events
   input wire ixr_pkg::fault_evt_t fault,
   input wire ixr_pkg::restart_evt_t restart_evt,
   input wire ixr_pkg::arith_evt_t arith,
   input wire logic shadow_extra_step,
   input wire logic nt_superpage_enable,
   input wire logic ic_data_parity_err,
   input wire logic ic_tag_parity_err,
   input wire logic ic_timeout_err,
   // translation lookup and status out
   input wire logic [63:0] lookup_va,
   output logic lookup_hit,
   output logic [63:0] lookup_pte,
   output logic icache_flush,
   output logic [63:0] return_target,
   output logic return_pal_mode
);

   initial begin
      if (entries < 2 || entries > 256) begin
         $error("entries out of range");
      end
   end

   localparam int pw = $clog2(entries);

   // ==========================================================
   // storage
   logic [ixr_pkg::tag_w-1:0] tag_stage;            // staged tag
   logic [ixr_pkg::tag_w-1:0] ent_tag [entries];    // entry tags
   logic [63:0] ent_pte [entries];                  // entry pte
   logic [entries-1:0] ent_valid;                   // entry valid
   logic [pw-1:0] replacement_pointer;              // not-last-used pointer
   logic [63:0] hold;                               // read hold
   logic [ixr_pkg::asn_w-1:0] address_space_number; // current space
   logic [ixr_pkg::asn_w-1:0] ent_asn [entries];    // entry space
   logic [63:0] fault_form;                         // formatted address
   logic [63:0] page_table_base;                    // base register
   logic data_parity_error_flag;
   logic tag_parity_error_flag;
   logic timeout_reset_error_flag;
   logic [63:0] restart_address;
   logic [6:0] trap_sum;                            // bits 16:10
   logic swc_blocked;                               // set by unmodified trap

   // decoded strobes
   logic wr_entry, rd_entry, wr_every, wr_process, wr_single, wr_sum;
   assign wr_entry = req.wr && req.idx == ixr_pkg::idx_xlate_entry_port;
   assign rd_entry = req.rd && req.idx == ixr_pkg::idx_xlate_entry_port;
   assign wr_every = req.wr && req.idx == ixr_pkg::idx_invalidate_every;
   assign wr_process = req.wr && req.idx == ixr_pkg::idx_invalidate_process;
   assign wr_single = req.wr && req.idx == ixr_pkg::idx_invalidate_single;
   assign wr_sum = req.wr && req.idx == ixr_pkg::idx_arith_trap_summary;

   logic any_fault;
   assign any_fault = fault.miss || fault.acc_vio;

   // ==========================================================
   // tag staging, loaded by hardware faults or software
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tag_stage <= '0;
      end else if (any_fault) begin
         tag_stage <= fault.va[ixr_pkg::va_tag_hi:ixr_pkg::va_tag_lo];
      end else if (req.wr && req.idx == ixr_pkg::idx_xlate_tag_stage) begin
         tag_stage <= req.wdata[ixr_pkg::va_tag_hi:ixr_pkg::va_tag_lo];
      end
   end

   // ==========================================================
   // replacement pointer; wraps so repeated writes cover all entries
   logic [pw-1:0] step;
   always_comb begin
      step = (shadow_extra_step && (wr_entry || rd_entry)) ? pw'(2) : pw'(1);
   end

   logic [pw-1:0] next_replacement_pointer;
   always_comb begin
      logic [pw:0] sum;
      sum = {1'b0, replacement_pointer} + {1'b0, step};
      if (sum >= (pw+1)'(entries)) begin
         sum = sum - (pw+1)'(entries);
      end
      next_replacement_pointer = sum[pw-1:0];
   end

   always_ff @(posedge clock) begin
      if (sys_rst || wr_every) begin
         replacement_pointer <= '0;
      end else if (wr_entry || rd_entry) begin
         replacement_pointer <= next_replacement_pointer;
      end
   end

   // ==========================================================
   // entry storage, one generate slice per entry
   genvar g;
   generate
      for (g = 0; g < entries; g++) begin : gen_ent
         logic tag_hit;
         assign tag_hit = ent_tag[g] == req.wdata[ixr_pkg::va_tag_hi:ixr_pkg::va_tag_lo];
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               ent_tag[g] <= '0;
               ent_pte[g] <= ixr_pkg::zero64;
               ent_asn[g] <= '0;
            end else if (wr_entry && replacement_pointer == pw'(g)) begin
               ent_tag[g] <= tag_stage;
               ent_pte[g] <= req.wdata;
               ent_asn[g] <= address_space_number;
            end
         end
         // invalidation beats a same-cycle fill of this same slot
         always_ff @(posedge clock) begin
            if (sys_rst || wr_every) begin
               ent_valid[g] <= 1'b0;
            end else if (wr_process && !ent_pte[g][ixr_pkg::pte_asm_bit]) begin
               ent_valid[g] <= 1'b0;
            end else if (wr_single && tag_hit && (ent_asn[g] == address_space_number
                         || ent_pte[g][ixr_pkg::pte_asm_bit])) begin
               ent_valid[g] <= 1'b0;
            end else if (wr_entry && replacement_pointer == pw'(g)) begin
               ent_valid[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // ==========================================================
   // space number
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         address_space_number <= '0;
      end else if (req.wr && req.idx == ixr_pkg::idx_space_number) begin
         address_space_number <= req.wdata[ixr_pkg::asn_lo +: ixr_pkg::asn_w];
      end
   end

   // ==========================================================
   // read hold with granularity hint decode
   logic [1:0] gh;
   logic [63:0] next_hold;
   always_comb begin
      gh = ent_pte[replacement_pointer][ixr_pkg::pte_gh_lo +: 2];
      next_hold = ent_pte[replacement_pointer];
      next_hold[ixr_pkg::ghd_bit0] = gh != 2'h0;
      next_hold[ixr_pkg::ghd_bit1] = gh[1];
      next_hold[ixr_pkg::ghd_bit2] = gh == 2'h3;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hold <= ixr_pkg::zero64;
      end else if (rd_entry) begin
         hold <= next_hold;
      end
   end

   // ==========================================================
   // formatted fault address and page table base
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_form <= ixr_pkg::zero64;
      end else if (any_fault && !(fault.acc_vio && fault.sign_check)) begin
         if (nt_superpage_enable) begin
            fault_form <= {page_table_base[63:ixr_pkg::page_table_base_field_nt_lo], 8'h00,
                           fault.va[ixr_pkg::nt_va_hi:ixr_pkg::va_tag_lo], 3'h0};
         end else begin
            fault_form <= {page_table_base[63:ixr_pkg::page_table_base_field_non_nt_lo],
                           fault.va[ixr_pkg::va_tag_hi:ixr_pkg::va_tag_lo], 3'h0};
         end
      end
   end

   // bits 32:30 kept as written; in non-nt mode they are don't-care on read
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         page_table_base <= ixr_pkg::zero64;
      end else if (req.wr && req.idx == ixr_pkg::idx_page_table_base) begin
         page_table_base <= {req.wdata[63:ixr_pkg::page_table_base_field_nt_lo], 30'h0};
      end
   end

   // ==========================================================
   // icache parity status: set wins over write-one clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         data_parity_error_flag <= 1'b0;
         tag_parity_error_flag <= 1'b0;
         timeout_reset_error_flag <= 1'b0;
      end else begin
         data_parity_error_flag <= ic_data_parity_err || (data_parity_error_flag
            && !(req.wr && req.idx == ixr_pkg::idx_icache_parity_status
                 && req.wdata[ixr_pkg::dpe_bit]));
         tag_parity_error_flag <= ic_tag_parity_err || (tag_parity_error_flag
            && !(req.wr && req.idx == ixr_pkg::idx_icache_parity_status
                 && req.wdata[ixr_pkg::tpe_bit]));
         timeout_reset_error_flag <= ic_timeout_err || (timeout_reset_error_flag
            && !(req.wr && req.idx == ixr_pkg::idx_icache_parity_status
                 && req.wdata[ixr_pkg::tmr_bit]));
      end
   end

   // ==========================================================
   // flush pulse, one cycle after the write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         icache_flush <= 1'b0;
      end else begin
         icache_flush <= req.wr && req.idx == ixr_pkg::idx_icache_flush_trigger;
      end
   end

   // ==========================================================
   // restart address; exception path has top priority
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         restart_address <= ixr_pkg::zero64;
      end else if (restart_evt.exc_take) begin
         restart_address <= restart_evt.precise ? restart_evt.fault_pc
                                                : restart_evt.next_pc;
      end else if (restart_evt.pal_call) begin
         restart_address <= restart_evt.call_next_pc;
      end else if (req.wr && req.idx == ixr_pkg::idx_restart_address) begin
         restart_address <= req.wdata;
      end
   end

   // return target registered from the restart address
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         return_target <= ixr_pkg::zero64;
         return_pal_mode <= 1'b0;
      end else begin
         return_target <= {restart_address[63:1], 1'b0};
         return_pal_mode <= restart_address[0];
      end
   end

   // ==========================================================
   // arithmetic trap summary; a trap in the write cycle still records
   logic [6:0] trap_bits;
   always_comb begin
      trap_bits = 7'h00;
      if (arith.trap) begin
         trap_bits = {arith.integer_convert_overflow_flag, arith.inexact_result_flag, arith.unf, arith.float_overflow_flag,
                      arith.divide_by_zero_flag, arith.invalid_operation_flag, 1'b0};
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         trap_sum <= 7'h00;
         swc_blocked <= 1'b0;
      end else if (wr_sum) begin
         trap_sum <= trap_bits;
         trap_sum[0] <= arith.trap && arith.sw_mod;
         swc_blocked <= arith.trap && !arith.sw_mod;
      end else if (arith.trap) begin
         trap_sum[6:1] <= trap_sum[6:1] | trap_bits[6:1];
         if (!arith.sw_mod) begin
            trap_sum[0] <= 1'b0;
            swc_blocked <= 1'b1;
         end else if (!swc_blocked) begin
            trap_sum[0] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // lookup port for the fetch path
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lookup_hit <= 1'b0;
         lookup_pte <= ixr_pkg::zero64;
      end else begin
         lookup_hit <= 1'b0;
         lookup_pte <= ixr_pkg::zero64;
         for (int i = 0; i < entries; i++) begin
            if (ent_valid[i] && ent_tag[i] == lookup_va[ixr_pkg::va_tag_hi:ixr_pkg::va_tag_lo]
                && (ent_asn[i] == address_space_number || ent_pte[i][ixr_pkg::pte_asm_bit])) begin
               lookup_hit <= 1'b1;
               lookup_pte <= ent_pte[i];
            end
         end
      end
   end

   // ==========================================================
   // read mux; write-only and unmapped indices read zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata <= ixr_pkg::zero64;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         rdata <= ixr_pkg::zero64;
         if (req.rd) begin
            case (req.idx)
               ixr_pkg::idx_xlate_entry_port: rdata <= ixr_pkg::zero64;
               ixr_pkg::idx_space_number: rdata <= 64'(address_space_number) << ixr_pkg::asn_lo;
               ixr_pkg::idx_entry_read_hold: rdata <= hold;
               ixr_pkg::idx_restart_address: rdata <= restart_address;
               ixr_pkg::idx_arith_trap_summary: rdata <= 64'(trap_sum) << ixr_pkg::swc_bit;
               ixr_pkg::idx_formatted_fault_address: rdata <= fault_form;
               ixr_pkg::idx_page_table_base: rdata <= page_table_base;
               ixr_pkg::idx_icache_parity_status: rdata <= {50'h0, timeout_reset_error_flag,
                  tag_parity_error_flag, data_parity_error_flag, 11'h000};
               default: rdata <= ixr_pkg::zero64;
            endcase
         end
      end
   end

endmodule : istream_xlate_and_exception_regs

`default_nettype wire

// ### logic/ixr_pkg.sv
/*
 * constants, register indices, field positions and carrier structs for the
 * instruction-stream translation and exception register bank.
 * assumes a single core clock and move-to/move-from register accesses
 * presented one per cycle by the issue logic.
 */
`default_nettype none

package ixr_pkg;

   // ==========================================================
   // register indices
   localparam logic [11:0] idx_xlate_tag_stage = 12'h101;
   localparam logic [11:0] idx_xlate_entry_port = 12'h102;
   localparam logic [11:0] idx_space_number = 12'h103;
   localparam logic [11:0] idx_entry_read_hold = 12'h104;
   localparam logic [11:0] idx_invalidate_every = 12'h105;
   localparam logic [11:0] idx_invalidate_process = 12'h106;
   localparam logic [11:0] idx_invalidate_single = 12'h107;
   localparam logic [11:0] idx_restart_address = 12'h10b;
   localparam logic [11:0] idx_arith_trap_summary = 12'h10c;
   localparam logic [11:0] idx_formatted_fault_address = 12'h112;
   localparam logic [11:0] idx_page_table_base = 12'h113;
   localparam logic [11:0] idx_icache_flush_trigger = 12'h119;
   localparam logic [11:0] idx_icache_parity_status = 12'h11a;

   // ==========================================================
   // field positions
   localparam int va_tag_hi = 42;
   localparam int va_tag_lo = 13;
   localparam int tag_w = va_tag_hi - va_tag_lo + 1;
   localparam int asn_lo = 4;
   localparam int asn_w = 7;
   localparam int pte_w = 64;
   localparam int pte_asm_bit = 4;          // match bit inside written entry
   localparam int pte_gh_lo = 5;            // granularity hint, two bits
   localparam int ghd_bit0 = 29;
   localparam int ghd_bit1 = 30;
   localparam int ghd_bit2 = 31;
   localparam int dpe_bit = 11;
   localparam int tpe_bit = 12;
   localparam int tmr_bit = 13;
   localparam int swc_bit = 10;
   localparam int inv_bit = 11;
   localparam int dze_bit = 12;
   localparam int fov_bit = 13;
   localparam int unf_bit = 14;
   localparam int ine_bit = 15;
   localparam int iov_bit = 16;
   localparam int page_table_base_field_non_nt_lo = 33;
   localparam int page_table_base_field_nt_lo = 30;
   localparam int form_va_lo = 3;
   localparam int nt_va_hi = 31;

   // ==========================================================
   // reset values
   localparam logic [63:0] zero64 = 64'h0000_0000_0000_0000;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic wr;                  // move_to_internal_register
      logic rd;                  // move_from_internal_register
      logic [11:0] idx;          // internal register index
      logic [63:0] wdata;        // written value
   } ipr_req_t;

   typedef struct packed {
      logic miss;                // istream_translation_miss
      logic acc_vio;             // istream_access_violation
      logic sign_check;          // violation came from sign check
      logic [63:0] va;           // faulting virtual address
   } fault_evt_t;

   typedef struct packed {
      logic exc_take;            // exception or interrupt reported
      logic precise;             // precise when set
      logic [63:0] fault_pc;     // pc of faulting instruction
      logic [63:0] next_pc;      // pc of next instruction to issue
      logic pal_call;            // privileged_library_call
      logic [63:0] call_next_pc; // pc after the call
   } restart_evt_t;

   typedef struct packed {
      logic trap;                // arithmetic trap completes
      logic sw_mod;              // software completion modifier present
      logic invalid_operation_flag;
      logic divide_by_zero_flag;
      logic float_overflow_flag;
      logic unf;
      logic inexact_result_flag;
      logic integer_convert_overflow_flag;
   } arith_evt_t;

endpackage : ixr_pkg

`default_nettype wire

// ### sim/istream_xlate_and_exception_regs_bench.sv
/*
 * directed bench for the translation and exception register bank.
 * assumes the one-cycle request and answer protocol of the bank's ports.
 */
`default_nettype none

module istream_xlate_and_exception_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // stimulus and observed signals
   logic clock;
   logic sys_rst;
   ixr_pkg::ipr_req_t req;
   logic [63:0] rdata;
   logic rvalid;
   ixr_pkg::fault_evt_t fault;
   ixr_pkg::restart_evt_t rs;
   ixr_pkg::arith_evt_t ar;
   logic nt;
   logic shx = 1'b0;               // shadowed access, pointer steps twice
   logic [2:0] perr;               // data, tag, timeout
   logic [63:0] lookup_va;
   logic lookup_hit;
   logic icache_flush;
   logic [63:0] return_target;
   logic return_pal_mode;
   int n_fail = 0;
   int checked = 0;
   logic [63:0] b = 64'hfedc_ba98_7654_3210; // page table base
   logic [11:0] rlist [7] = '{12'h103, 12'h104, 12'h10b, 12'h10c, 12'h112, 12'h113, 12'h11a};

   // small entry count keeps the wrap visible
   istream_xlate_and_exception_regs #(.entries(4)) DUT (.clock(clock), .sys_rst(sys_rst),
      .req(req), .rdata(rdata), .rvalid(rvalid), .fault(fault), .restart_evt(rs), .arith(ar),
      .shadow_extra_step(shx), .nt_superpage_enable(nt), .ic_data_parity_err(perr[0]),
      .ic_tag_parity_err(perr[1]), .ic_timeout_err(perr[2]), .lookup_va(lookup_va),
      .lookup_hit(lookup_hit), .lookup_pte(), .icache_flush(icache_flush),
      .return_target(return_target), .return_pal_mode(return_pal_mode));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ==========================================================
   // access tasks, all driven on the falling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic conclude;
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [11:0] idx, input logic [63:0] d);
      req.wr = 1'b1;
      req.idx = idx;
      req.wdata = d;
      tick(1);
      req.wr = 1'b0;
   endtask : wr
   // read, mask, compare; bounded wait for the answer
   task automatic rc(input logic [11:0] idx, input logic [63:0] m, input logic [63:0] exp);
      int k;
      req.rd = 1'b1;
      req.idx = idx;
      tick(1);
      req.rd = 1'b0;
      for (k = 0; k < 4 && rvalid !== 1'b1; k++) tick(1);
      if (k == 4) begin
         n_fail++;
         conclude();
      end
      cmp(rdata & m, exp);
   endtask : rc
   task automatic flt(input logic [63:0] a, input logic n, input logic sc);
      fault.va = a;
      fault.miss = !sc;
      fault.acc_vio = sc;
      fault.sign_check = sc;
      nt = n;
      tick(1);
      fault = '0;
   endtask : flt
   task automatic look(input logic [63:0] a, input logic exp);
      lookup_va = a;
      tick(2);
      cmp({63'h0, lookup_hit}, {63'h0, exp});
   endtask : look
   // restart event racing a software write of 0x4000
   task automatic rse(input logic e, input logic p, input logic c);
      rs = '{e, p, 64'h2000, 64'h2004, c, 64'h3001};
      req.wr = 1'b1;
      req.idx = 12'h10b;
      req.wdata = 64'h4000;
      tick(1);
      rs = '0;
      req.wr = 1'b0;
      tick(2);
   endtask : rse
   task automatic trp(input logic s, input logic [5:0] k);
      ar = {1'b1, s, k};             // inv down to iov
      tick(1);
      ar = '0;
   endtask : trp
   function automatic logic [29:0] vt(input int n);
      return 30'h1234 + 30'(n * 16'h111);
   endfunction : vt
   function automatic logic [63:0] va(input int n);
      return {21'h0, vt(n), 13'h0};
   endfunction : va
   function automatic logic [63:0] granularity_hint_decode(input int g);
      return {32'h0, g >= 3, g >= 2, g >= 1, 29'h0};
   endfunction : granularity_hint_decode

   // ==========================================================
   // main sequence
   initial begin
      int i;
      req = '0;
      fault = '0;
      rs = '0;
      ar = '0;
      nt = 1'b0;
      perr = 3'h0;
      lookup_va = 64'h0;
      sys_rst = 1'b1;
      tick(20);
      sys_rst = 1'b0;
      foreach (rlist[i]) rc(rlist[i], '1, 64'h0);
      rc(12'h1ff, '1, 64'h0);
      $display("test reset done");
      // fill all four entries, hint i, match bit on entry 1
      wr(12'h105, 64'h0);
      wr(12'h103, 64'h50);
      rc(12'h103, 64'h7f0, 64'h50);
      for (i = 0; i < 4; i++) begin
         flt(va(i), 1'b0, 1'b0);
         wr(12'h102, {57'h0, i[1:0], i == 1, 4'h0});
      end
      for (i = 0; i < 4; i++) begin
         rc(12'h102, '1, 64'h0);
         rc(12'h104, 64'he000_0000, granularity_hint_decode(i));
      end
      for (i = 0; i < 4; i++) look(va(i), 1'b1);
      $display("test fill done");
      // other space leaves entry 2, own space drops entry 3
      wr(12'h103, 64'h60);
      wr(12'h107, va(2));
      wr(12'h103, 64'h50);
      wr(12'h107, va(3));
      look(va(2), 1'b1);
      look(va(3), 1'b0);
      wr(12'h106, 64'h0);
      look(va(0), 1'b0);
      look(va(1), 1'b1);
      rc(12'h102, '1, 64'h0);
      wr(12'h105, 64'h0);
      look(va(1), 1'b0);
      wr(12'h102, 64'h60);
      rc(12'h102, '1, 64'h0);
      rc(12'h104, 64'he000_0000, granularity_hint_decode(1));
      shx = 1'b1;
      rc(12'h102, '1, 64'h0);
      shx = 1'b0;
      rc(12'h102, '1, 64'h0);
      rc(12'h102, '1, 64'h0);
      rc(12'h104, 64'he000_0000, granularity_hint_decode(1));
      $display("test invalidate done");
      // formatted fault address in both modes
      wr(12'h113, b);
      rc(12'h113, 64'hffff_fffe_0000_0000, {b[63:33], 33'h0});
      flt(va(5), 1'b0, 1'b0);
      rc(12'h112, '1, {b[63:33], vt(5), 3'h0});
      flt(va(6), 1'b0, 1'b1);
      rc(12'h112, '1, {b[63:33], vt(5), 3'h0});
      flt(va(7), 1'b1, 1'b0);
      rc(12'h112, '1, {b[63:30], 8'h0, 19'(vt(7)), 3'h0});
      rc(12'h113, '1, {b[63:30], 30'h0});
      $display("test fault done");
      // parity flags, flush pulse
      perr = 3'h7;
      tick(1);
      perr = 3'h0;
      rc(12'h11a, '1, 64'h3800);
      wr(12'h11a, 64'h800);
      rc(12'h11a, '1, 64'h3000);
      wr(12'h119, 64'h5a);
      cmp({63'h0, icache_flush}, 64'h1);
      $display("test icache done");
      // restart address sources and precedence
      wr(12'h10b, 64'h1000_0001);
      tick(1);
      cmp(return_target, 64'h1000_0000);
      cmp({63'h0, return_pal_mode}, 64'h1);
      rse(1'b1, 1'b1, 1'b1);
      rc(12'h10b, '1, 64'h2000);
      rse(1'b1, 1'b0, 1'b0);
      rc(12'h10b, '1, 64'h2004);
      rse(1'b0, 1'b0, 1'b1);
      rc(12'h10b, '1, 64'h3001);
      $display("test restart done");
      // summary accumulation and completion flag
      trp(1'b1, 6'b100000);
      rc(12'h10c, '1, 64'h0c00);
      trp(1'b0, 6'b010000);
      rc(12'h10c, '1, 64'h1800);
      trp(1'b1, 6'b001000);
      rc(12'h10c, '1, 64'h3800);
      wr(12'h10c, '1);
      rc(12'h10c, '1, 64'h0);
      trp(1'b1, 6'b000111);
      rc(12'h10c, '1, 64'h1_c400);
      $display("test summary done");
      conclude();
   end
endmodule : istream_xlate_and_exception_regs_bench

bind istream_xlate_and_exception_regs ixr_properties chk (.clock(clock), .sys_rst(sys_rst),
   .req(req), .rdata(rdata), .rvalid(rvalid), .restart_evt(restart_evt),
   .icache_flush(icache_flush), .return_target(return_target), .return_pal_mode(return_pal_mode));

`default_nettype wire

// ### sim/ixr_properties.sv
/*
 * port-level checks for the translation and exception register bank.
 * assumes one core clock, synchronous active-high reset, bound to the top.
 */
`default_nettype none

module ixr_properties (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register access
   input wire ixr_pkg::ipr_req_t req,
   input wire logic [63:0] rdata,
   input wire logic rvalid,
   // restart events and status out
   input wire ixr_pkg::restart_evt_t restart_evt,
   input wire logic icache_flush,
   input wire logic [63:0] return_target,
   input wire logic return_pal_mode
);
   // ==========================================================
   // single domain: reset masks every check
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // read answered in the next cycle, nothing unasked
   property p_read_answer;
      req.rd |=> rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered in one cycle");
   property p_no_stray_answer;
      !req.rd |=> !rvalid;
   endproperty
   a_no_stray_answer: assert property (p_no_stray_answer)
      else $error("answer without read");
   // entry port read gives zero to the register file
   property p_entry_read_zero;
      req.rd && req.idx == ixr_pkg::idx_xlate_entry_port |=> rdata == 64'h0;
   endproperty
   a_entry_read_zero: assert property (p_entry_read_zero)
      else $error("entry port read not zero");
   // flush pulse exactly after a flush write
   property p_flush_pulse;
      req.wr && req.idx == ixr_pkg::idx_icache_flush_trigger |=> icache_flush;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse)
      else $error("flush write gave no pulse");
   property p_flush_only;
      !(req.wr && req.idx == ixr_pkg::idx_icache_flush_trigger) |=> !icache_flush;
   endproperty
   a_flush_only: assert property (p_flush_only)
      else $error("flush pulse without write");
   // restart target two cycles on: register, then its copy
   property p_precise_pc;
      restart_evt.exc_take && restart_evt.precise |->
         ##2 return_target == {$past(restart_evt.fault_pc[63:1], 2), 1'b0};
   endproperty
   a_precise_pc: assert property (p_precise_pc)
      else $error("precise restart target wrong");
   property p_imprecise_pc;
      restart_evt.exc_take && !restart_evt.precise |->
         ##2 return_target == {$past(restart_evt.next_pc[63:1], 2), 1'b0};
   endproperty
   a_imprecise_pc: assert property (p_imprecise_pc)
      else $error("imprecise restart target wrong");
   property p_call_pc;
      restart_evt.pal_call && !restart_evt.exc_take |->
         ##2 return_target == {$past(restart_evt.call_next_pc[63:1], 2), 1'b0}
         && return_pal_mode == $past(restart_evt.call_next_pc[0], 2);
   endproperty
   a_call_pc: assert property (p_call_pc)
      else $error("call restart target wrong");
   // reserved bits of status reads stay zero
   property p_parity_read;
      req.rd && req.idx == ixr_pkg::idx_icache_parity_status |=>
         rdata[63:14] == 50'h0 && rdata[10:0] == 11'h0;
   endproperty
   a_parity_read: assert property (p_parity_read)
      else $error("parity status reserved bits set");
   property p_summary_read;
      req.rd && req.idx == ixr_pkg::idx_arith_trap_summary |=>
         rdata[63:17] == 47'h0 && rdata[9:0] == 10'h0;
   endproperty
   a_summary_read: assert property (p_summary_read)
      else $error("summary reserved bits set");
endmodule : ixr_properties

`default_nettype wire
